//--- rtl/smcfg_regs.svh
// register offsets, field limits, reset values and timing counts of the string monitor configuration block
// assumes a 125 MHz system clock; offsets are modbus holding register numbers
`ifndef SMCFG_REGS_SVH
`define SMCFG_REGS_SVH

`define SMC_ADDR_MEAS_MODE 16'h00CE
`define SMC_ADDR_HOLDOFF 16'h00D0
`define SMC_ADDR_FORMAT 16'h00D1
`define SMC_ADDR_LOW_POWER 16'h012C
`define SMC_ADDR_TRIGGER 16'h012E
`define SMC_ADDR_SNAP_ID 16'h003B
`define SMC_ADDR_SNAP_FIRST 16'h003C
`define SMC_ADDR_SNAP_LAST 16'h0065
`define SMC_SNAP_WORDS 42

`define SMC_HOLDOFF_MAX 16'h00FA
`define SMC_FMT_EVEN_BASE 8'h64
`define SMC_FMT_ODD_BASE 8'hC8
`define SMC_FMT_UNITS_MAX 8'h05
`define SMC_FMT_RESET 8'h04
`define SMC_DATA_BITS 4'h8
`define SMC_STOP_BITS 2'h1

`define SMC_CLK_PERIOD_NS 8
`define SMC_CLK_HZ 125000000
`define SMC_MS_NS 1000000
`define SMC_MS_CYCLES ((`SMC_MS_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_REPLY_DEF_MS 9'h014
`define SMC_REPLY_FAST_MS 9'h006
`define SMC_REFRESH_DEF_MS 10'h3E8
`define SMC_REFRESH_FAST_MS 10'h064
`define SMC_WAKE_PERIOD_MS 16'hEA60

`endif

//--- rtl/smcfg_pkg.sv
// types shared by the string monitor configuration block
// assumes smcfg_regs.svh on the include path
`include "smcfg_regs.svh"

package smcfg_pkg;

  typedef enum logic [1:0] {SMCFG_PAR_NONE, SMCFG_PAR_EVEN, SMCFG_PAR_ODD} smcfg_parity_t;
  typedef enum logic {SMCFG_RP_IDLE, SMCFG_RP_WAIT} smcfg_reply_t;
  typedef logic [`SMC_SNAP_WORDS-1:0][15:0] smcfg_snap_t;

  typedef struct packed {
    smcfg_parity_t parity;
    logic [2:0] baud_idx;
    logic [3:0] data_bits;
    logic [1:0] stop_bits;
    logic [16:0] bit_cycles;
  } smcfg_line_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } smcfg_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } smcfg_bus_rsp_t;

  typedef struct packed {
    smcfg_bus_rsp_t rsp;
    logic [7:0] holdoff;
    logic [7:0] fmt;
    smcfg_line_t line;
    logic fast;
    logic low_power;
    logic [15:0] trig;
    logic snap_valid;
    smcfg_snap_t snap;
    logic [16:0] ms_div;
    logic ms_tick;
    smcfg_reply_t rp;
    logic [8:0] reply_cnt;
    logic tx_start;
    logic [9:0] win_cnt;
    logic [15:0] min_cnt;
    logic meas_power;
    logic meas_update;
    logic backlight;
    logic comm_active;
  } smcfg_state_t;

endpackage : smcfg_pkg

//--- rtl/smcfg_top.sv
// configuration and control registers of a string current monitor behind a modbus slave
// assumes the modbus engine and the measurement front end run on clk and hand over one-cycle pulses
`timescale 1ns/1ns
`include "smcfg_regs.svh"

module smcfg_top
  import smcfg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SMC_MS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire smcfg_bus_req_t bus_req,
  output smcfg_bus_rsp_t bus_rsp,
  input wire smcfg_snap_t meas_live,
  input wire logic rx_req,
  output logic tx_start,
  output smcfg_line_t line_cfg,
  output logic meas_fast,
  output logic meas_power,
  output logic meas_update,
  output logic backlight_on,
  output logic comm_active,
  output logic low_power_mode,
  output logic snap_valid
);

  smcfg_state_t q;
  smcfg_state_t n;
  logic [5:0] snap_idx;
  logic [8:0] reply_base;
  logic [9:0] refresh_ms;

  function automatic logic fmt_ok(input logic [15:0] code);
    fmt_ok = (code <= 16'(`SMC_FMT_UNITS_MAX))
          || (code >= 16'(`SMC_FMT_EVEN_BASE) && code <= 16'(`SMC_FMT_EVEN_BASE + `SMC_FMT_UNITS_MAX))
          || (code >= 16'(`SMC_FMT_ODD_BASE) && code <= 16'(`SMC_FMT_ODD_BASE + `SMC_FMT_UNITS_MAX));
  endfunction : fmt_ok

  function automatic logic [16:0] bit_time(input logic [2:0] idx);
    int unsigned baud;
    // the six rates double from 1200 upward, so one shift replaces a table
    baud = 32'h0000_04B0 << idx;
    bit_time = 17'((`SMC_CLK_HZ + baud / 2) / baud);
  endfunction : bit_time

  function automatic smcfg_line_t line_decode(input logic [7:0] code);
    smcfg_line_t l;
    logic [7:0] units;
    l = '0;
    l.parity = (code >= `SMC_FMT_ODD_BASE) ? SMCFG_PAR_ODD
             : (code >= `SMC_FMT_EVEN_BASE) ? SMCFG_PAR_EVEN : SMCFG_PAR_NONE;
    units = (code >= `SMC_FMT_ODD_BASE) ? code - `SMC_FMT_ODD_BASE
          : (code >= `SMC_FMT_EVEN_BASE) ? code - `SMC_FMT_EVEN_BASE : code;
    l.baud_idx = units[2:0];
    l.data_bits = `SMC_DATA_BITS;
    l.stop_bits = `SMC_STOP_BITS;
    l.bit_cycles = bit_time(units[2:0]);
    line_decode = l;
  endfunction : line_decode

  assign snap_idx = 6'(bus_req.addr - `SMC_ADDR_SNAP_FIRST);
  assign reply_base = q.fast ? `SMC_REPLY_FAST_MS : `SMC_REPLY_DEF_MS;
  assign refresh_ms = q.fast ? `SMC_REFRESH_FAST_MS : `SMC_REFRESH_DEF_MS;

  always_comb
  begin
    n = q;
    n.rsp.ack = 1'b0;
    n.tx_start = 1'b0;
    n.meas_update = 1'b0;
    n.comm_active = 1'b1;
    n.backlight = ~q.low_power;
    n.ms_tick = (q.ms_div == 17'(MS_CYCLES - 1));
    n.ms_div = n.ms_tick ? 17'h0_0000 : q.ms_div + 17'h0_0001;

    // reply pacing: base latency plus holdoff, counted in ms ticks
    case (q.rp)
      SMCFG_RP_IDLE:
      begin
        if (rx_req)
        begin
          n.rp = SMCFG_RP_WAIT;
          n.reply_cnt = reply_base + {1'b0, q.holdoff};
        end
      end
      SMCFG_RP_WAIT:
      begin
        if (rx_req)
          n.reply_cnt = reply_base + {1'b0, q.holdoff};
        else if (q.reply_cnt == 9'h000)
        begin
          n.tx_start = 1'b1;
          n.rp = SMCFG_RP_IDLE;
        end
        else if (q.ms_tick)
        begin
          n.reply_cnt = q.reply_cnt - 9'h001;
        end
      end
      default: n.rp = SMCFG_RP_IDLE;
    endcase

    // measurement duty: continuous in full mode, one window per minute in low power
    if (!q.low_power)
    begin
      n.meas_power = 1'b1;
      n.min_cnt = '0;
    end
    else if (q.ms_tick)
    begin
      if (q.min_cnt == `SMC_WAKE_PERIOD_MS - 16'h0001)
      begin
        n.min_cnt = '0;
        n.meas_power = 1'b1;
      end
      else
      begin
        n.min_cnt = q.min_cnt + 16'h0001;
      end
    end
    if (!q.meas_power)
      n.win_cnt = '0;
    else if (q.ms_tick)
    begin
      if (q.win_cnt >= refresh_ms - 10'h001)
      begin
        n.win_cnt = '0;
        n.meas_update = 1'b1;
        if (q.low_power)
        begin
          n.meas_power = 1'b0;
        end
      end
      else
      begin
        n.win_cnt = q.win_cnt + 10'h001;
      end
    end

    if (bus_req.req)
    begin
      n.rsp.ack = 1'b1;
      n.rsp.rdata = '0;
      if (bus_req.we)
      begin
        // a refused value keeps the old setting, yet the access is still acknowledged
        if (bus_req.addr == `SMC_ADDR_HOLDOFF && bus_req.wdata <= `SMC_HOLDOFF_MAX)
        begin
          n.holdoff = bus_req.wdata[7:0];
        end
        else if (bus_req.addr == `SMC_ADDR_FORMAT && fmt_ok(bus_req.wdata))
        begin
          n.fmt = bus_req.wdata[7:0];
          n.line = line_decode(bus_req.wdata[7:0]);
        end
        else if (bus_req.addr == `SMC_ADDR_MEAS_MODE && bus_req.wdata <= 16'h0001)
        begin
          n.fast = bus_req.wdata[0];
          n.win_cnt = '0;
        end
        else if (bus_req.addr == `SMC_ADDR_LOW_POWER && bus_req.wdata <= 16'h0001)
        begin
          n.low_power = bus_req.wdata[0];
        end
        else if (bus_req.addr == `SMC_ADDR_TRIGGER)
        begin
          n.trig = bus_req.wdata;
          n.snap = meas_live;
          n.snap_valid = 1'b1;
        end
      end
      else
      begin
        if (bus_req.addr == `SMC_ADDR_HOLDOFF)
          n.rsp.rdata = {8'h00, q.holdoff};
        else if (bus_req.addr == `SMC_ADDR_FORMAT)
          n.rsp.rdata = {8'h00, q.fmt};
        else if (bus_req.addr == `SMC_ADDR_MEAS_MODE)
          n.rsp.rdata = {15'h0000, q.fast};
        else if (bus_req.addr == `SMC_ADDR_LOW_POWER)
          n.rsp.rdata = {15'h0000, q.low_power};
        else if (bus_req.addr == `SMC_ADDR_TRIGGER || bus_req.addr == `SMC_ADDR_SNAP_ID)
          n.rsp.rdata = q.trig;
        else if (bus_req.addr >= `SMC_ADDR_SNAP_FIRST && bus_req.addr <= `SMC_ADDR_SNAP_LAST)
          n.rsp.rdata = q.snap[snap_idx];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.fmt <= `SMC_FMT_RESET;
      q.line <= line_decode(`SMC_FMT_RESET);
      q.meas_power <= 1'b1;
      q.backlight <= 1'b1;
      q.comm_active <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign bus_rsp = q.rsp;
  assign tx_start = q.tx_start;
  assign line_cfg = q.line;
  assign meas_fast = q.fast;
  assign meas_power = q.meas_power;
  assign meas_update = q.meas_update;
  assign backlight_on = q.backlight;
  assign comm_active = q.comm_active;
  assign low_power_mode = q.low_power;
  assign snap_valid = q.snap_valid;

  // helper: ms ticks consumed by the pending reply against the figure it was loaded with
  logic [8:0] h_ticks;
  logic [8:0] h_need;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      h_ticks <= '0;
      h_need <= '0;
    end
    else if (rx_req)
    begin
      h_ticks <= '0;
      h_need <= (q.fast ? 9'h006 : 9'h014) + {1'b0, q.holdoff};
    end
    else if (q.rp == SMCFG_RP_WAIT && q.ms_tick && q.reply_cnt != 9'h000)
    begin
      h_ticks <= h_ticks + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reply_holdoff: assert property (tx_start |-> h_ticks == h_need)
    else $error("reply released after wrong number of ms");
  a_reply_base: assert property (rx_req && q.holdoff == 8'h00
    |=> q.reply_cnt == ($past(meas_fast) ? 9'h006 : 9'h014))
    else $error("zero holdoff did not load base latency");
  a_holdoff_range: assert property (bus_req.req && bus_req.we && bus_req.addr == 16'h00D0 && bus_req.wdata > 16'h00FA
    |=> $stable(q.holdoff))
    else $error("out of range holdoff accepted");
  a_format_legal: assert property (fmt_ok({8'h00, q.fmt}) && line_cfg == line_decode(q.fmt))
    else $error("line format illegal or mismatched");
  a_frame_shape: assert property (line_cfg.data_bits == 4'h8 && line_cfg.stop_bits == 2'h1)
    else $error("framing not eight data one stop");
  a_reset_format: assert property ($rose(rst_b) |-> line_cfg.parity == SMCFG_PAR_NONE && line_cfg.baud_idx == 3'h4)
    else $error("reset line format not 19200 no parity");
  a_refresh_window: assert property (q.win_cnt <= refresh_ms - 10'h001)
    else $error("refresh window overran");
  a_eco_off: assert property ($past(low_power_mode) && meas_update |-> !meas_power)
    else $error("measurement left powered in low power");
  a_backlight_eco: assert property (low_power_mode ##1 low_power_mode |-> !backlight_on)
    else $error("backlight on in low power");
  a_comm_alive: assert property (comm_active) else $error("communication section dropped");
  a_snap_copy: assert property (bus_req.req && bus_req.we && bus_req.addr == 16'h012E
    |=> q.snap == $past(meas_live) && q.trig == $past(bus_req.wdata) && snap_valid)
    else $error("snapshot not captured on trigger");

  c_trigger: cover property (bus_req.req && bus_req.we && bus_req.addr == 16'h012E ##1 snap_valid);
  c_reply_fast: cover property (meas_fast && tx_start);
  c_eco_update: cover property (low_power_mode && meas_update);
  c_format_odd: cover property (line_cfg.parity == SMCFG_PAR_ODD);

endmodule : smcfg_top

//--- verif/smcfg_master.sv
// modbus master stand-in that turns register accesses into one-cycle requests
// assumes the slave samples bus_req on the rising edge of clk
`timescale 1ns/1ns
`include "smcfg_regs.svh"

module smcfg_master
  import smcfg_pkg::*;
(
  input wire logic clk,
  output smcfg_bus_req_t bus_req
);
  initial bus_req = '0;

  // idle fields carry inverted junk so a slave that samples late is caught
  task automatic xfer(input logic we, input logic [15:0] addr, input logic [15:0] wdata);
    @(posedge clk);
    #1;
    bus_req = '{req: 1'b1, we: we, addr: addr, wdata: wdata};
    @(posedge clk);
    #1;
    bus_req = '{req: 1'b0, we: ~we, addr: ~addr, wdata: ~wdata};
  endtask : xfer

  // only the trigger goes out here; the caller issues the snapshot reads after it
  task automatic snap_sync(input logic [15:0] id);
    xfer(1'b1, `SMC_ADDR_TRIGGER, id);
  endtask : snap_sync
endmodule : smcfg_master

//--- verif/smcfg_top_tb_top.sv
// self-checking bench for the string monitor configuration block
// assumes smcfg_master drives the register bus; a millisecond is shortened to MS clocks
`timescale 1ns/1ns
`include "smcfg_regs.svh"

module smcfg_top_tb_top;
  import smcfg_pkg::*;
  localparam int MS = 20;
  localparam logic [15:0] GOOD[12] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0065,
    16'h0068, 16'h0064, 16'h00CB, 16'h00CD, 16'h0066, 16'h00CC};
  localparam logic [15:0] BAD[3] = '{16'h006A, 16'h0006, 16'h012C};
  localparam int BAUD[6] = '{32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0, 32'h0000_2580, 32'h0000_4B00,
    32'h0000_9600};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rx_req = 1'b0;
  smcfg_snap_t meas_live = '0;
  smcfg_bus_req_t bus_req;
  smcfg_bus_rsp_t bus_rsp;
  smcfg_line_t line_cfg;
  logic tx_start, meas_fast, meas_power, meas_update, backlight_on, comm_active, low_power_mode, snap_valid;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  logic [31:0] rnd = 32'h0000_E54B;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  smcfg_master u_mst (.clk(clk), .bus_req(bus_req));

  smcfg_top #(.MS_CYCLES(MS)) u_dut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .meas_live(meas_live), .rx_req(rx_req), .tx_start(tx_start), .line_cfg(line_cfg),
    .meas_fast(meas_fast), .meas_power(meas_power), .meas_update(meas_update),
    .backlight_on(backlight_on), .comm_active(comm_active), .low_power_mode(low_power_mode),
    .snap_valid(snap_valid));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s exp %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    exp_q.push_back(16'h0000);
    u_mst.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_mst.xfer(1'b0, a, 16'h0000);
  endtask : rd

  // reply must land inside the tick window that n milliseconds allow
  task automatic pace(input int n);
    int t0;
    @(posedge clk);
    #1 rx_req = 1'b1;
    t0 = cyc;
    @(posedge clk);
    #1 rx_req = 1'b0;
    repeat (n * MS + 8)
    begin
      @(posedge clk);
      if (tx_start === 1'b1)
        break;
    end
    check("reply", (cyc - t0 >= (n - 1) * MS + 2) && (cyc - t0 <= n * MS + 4), 1);
  endtask : pace

  // first pulse after a mode write restarts timing, the second gives the period
  task automatic gap(input int p);
    int t0;
    repeat (2)
    begin
      t0 = cyc;
      repeat (p * MS + 8)
      begin
        @(posedge clk);
        if (meas_update === 1'b1)
          break;
      end
    end
    check("period", cyc - t0, p * MS);
  endtask : gap

  always @(posedge clk)
  begin
    if (bus_rsp.ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("ack", 1, 0);
      else
        check("rdata", bus_rsp.rdata, exp_q.pop_front());
    end
  end

  initial
  begin
    #800000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    int h;
    smcfg_snap_t old;
    for (int i = 0; i < `SMC_SNAP_WORDS; i++)
    begin
      rnd = xs(rnd);
      meas_live[i] = rnd[15:0];
    end
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    check("parity", line_cfg.parity, SMCFG_PAR_NONE);
    check("baud", line_cfg.baud_idx, 3'h4);
    check("frame", {line_cfg.data_bits, line_cfg.stop_bits}, {`SMC_DATA_BITS, `SMC_STOP_BITS});
    check("modes", {low_power_mode, backlight_on, comm_active, snap_valid, meas_power}, 5'h0D);
    rd(`SMC_ADDR_HOLDOFF, 16'h0000);
    rd(`SMC_ADDR_SNAP_FIRST, 16'h0000);
    foreach (GOOD[i])
    begin
      wr(`SMC_ADDR_FORMAT, GOOD[i]);
      rd(`SMC_ADDR_FORMAT, GOOD[i]);
      check("parity", line_cfg.parity, GOOD[i] / 100);
      check("baud", line_cfg.baud_idx, GOOD[i] % 100);
      check("bit_time", line_cfg.bit_cycles, (`SMC_CLK_HZ + BAUD[GOOD[i] % 100] / 2) / BAUD[GOOD[i] % 100]);
      check("stop", line_cfg.stop_bits, `SMC_STOP_BITS);
    end
    foreach (BAD[i])
    begin
      wr(`SMC_ADDR_FORMAT, BAD[i]);
      rd(`SMC_ADDR_FORMAT, 16'h00CC);
    end
    wr(`SMC_ADDR_HOLDOFF, 16'h00FA);
    wr(`SMC_ADDR_HOLDOFF, 16'h00FB);
    rd(`SMC_ADDR_HOLDOFF, 16'h00FA);
    rnd = xs(rnd);
    h = rnd[1:0] + 1;
    wr(`SMC_ADDR_HOLDOFF, 16'(h));
    for (int m = 0; m < 2; m++)
    begin
      wr(`SMC_ADDR_MEAS_MODE, 16'(m));
      check("fast", meas_fast, m);
      gap(m ? 100 : 1000);
      pace(m ? 6 + h : 20 + h);
    end
    wr(`SMC_ADDR_HOLDOFF, 16'h0000);
    pace(6);
    old = meas_live;
    rnd = xs(rnd);
    exp_q.push_back(16'h0000);
    u_mst.snap_sync(rnd[15:0]);
    meas_live = ~meas_live;
    check("snap_valid", snap_valid, 1);
    rd(`SMC_ADDR_SNAP_ID, rnd[15:0]);
    rd(`SMC_ADDR_TRIGGER, rnd[15:0]);
    rd(`SMC_ADDR_SNAP_FIRST, old[0]);
    rd(`SMC_ADDR_SNAP_LAST, old[`SMC_SNAP_WORDS-1]);
    wr(16'h0200, 16'h1234);
    rd(16'h0200, 16'h0000);
    wr(`SMC_ADDR_LOW_POWER, 16'h0001);
    wr(`SMC_ADDR_LOW_POWER, 16'h0002);
    rd(`SMC_ADDR_LOW_POWER, 16'h0001);
    check("lp", {low_power_mode, backlight_on, comm_active}, 3'h5);
    // the running fast window ends within 100 ms, then the measurement section must be off
    repeat (100 * MS + 8)
    begin
      @(posedge clk);
      if (meas_update === 1'b1)
        break;
    end
    @(posedge clk);
    check("meas_power", meas_power, 0);
    wr(`SMC_ADDR_LOW_POWER, 16'h0000);
    repeat (2) @(posedge clk);
    check("lp", {low_power_mode, backlight_on, comm_active}, 3'h3);
    repeat (4) @(posedge clk);
    check("queue", exp_q.size(), 0);
    tally_and_finish();
  end
endmodule : smcfg_top_tb_top
